// >>> logic/perf_counter.sv
`timescale 1ns/10ps
module perf_counter
    import perf_monitor_pkg::*;
(
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic             i_enable,
    input  wire logic             i_start,
    input  wire logic             i_event,
    input  wire logic             i_clear,
    input  wire logic             i_wr,
    input  wire logic [CNT_W-1:0] i_wdata,
    input  wire logic             i_ovf_clr,
    output logic      [CNT_W-1:0] o_count,
    output logic                  o_overflow_n
);
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    logic             ovf_n_ff;
    logic             nxt_ovf_n;
    logic             wrap;

    always_comb begin
        nxt_count = count_ff;
        wrap      = 1'b0;
        if (i_clear) begin
            nxt_count = COUNT_RST;
        end else if (i_wr && i_enable) begin
            // A write to a gated counter is lost
            nxt_count = i_wdata;
        end else if (i_enable && i_start && i_event) begin
            nxt_count = count_ff + 32'h00000001;
            wrap      = (count_ff == 32'hFFFFFFFF);
        end
        // Set beats clear when both land together
        nxt_ovf_n = ~(wrap | (~ovf_n_ff & ~i_ovf_clr));
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_ff <= COUNT_RST;
            ovf_n_ff <= 1'b1;
        end else begin
            count_ff <= nxt_count;
            ovf_n_ff <= nxt_ovf_n;
        end
    end

    assign o_count      = count_ff;
    // Flag is held inverted so the pin comes straight from the flop
    assign o_overflow_n = ovf_n_ff;

    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);

    a_clear_zero: assert property (i_clear |=> count_ff == 32'h0)
        else $error("counter not cleared");
    a_stop_hold: assert property (!i_clear && !i_wr && !(i_start && i_enable)
        |=> $stable(count_ff))
        else $error("counter moved while stopped");
    a_step_one: assert property (!i_clear && !i_wr && count_ff != 32'hFFFFFFFF
        |=> count_ff - $past(count_ff) <= 32'h1)
        else $error("counter stepped by more than one");
    a_gated_write: assert property (i_wr && !i_enable && !i_clear
        |=> $stable(count_ff))
        else $error("write to disabled counter took effect");
    a_wrap_flag: assert property (count_ff == 32'hFFFFFFFF && i_event && i_enable
        && i_start && !i_clear && !i_wr |=> count_ff == 32'h0 && !o_overflow_n)
        else $error("wrap did not raise overflow");
endmodule

// >>> logic/perf_event_monitor.sv
`timescale 1ns/10ps
// Overview of operation
// - Eight 32-bit counters, each can select any single event.
// - Global start bit lets counters increment only while high; resets low.
// - Global counter reset clears every counter to zero.
// - Export bus shows every event in parallel, one bit each.
// - Counting and export enabled only when either debug enable is high.
// - Secure debug enables decide whether secure events are also counted.
// - One active-low overflow output per counter.
// - Each port and the snoop filter produce events independently.
// - Coherent-only events fire only on full-coherent ports.
// - Each event fires at most once per cycle.
// - Selection is 4-bit source id above 5-bit event code.
// - Encodings fixed; absent or reserved sources produce no events.
// - Slave codes 0x00-0x07 count read address handshakes by kind.
// - 0x08 read data handshakes, 0x09 last-beat snoop hit data.
// - Slave codes 0x0A-0x10 count write address handshakes by kind.
// - Slave code 0x11 never fires.
// - 0x12 write data, 0x13 snoop address, 0x14 snoop read, 0x15 clean.
// - 0x16 counts snoop responses with data-transfer bit low.
// - 0x17-0x1D count valid-high ready-low cycles per slave channel.
// - 0x1E outstanding limit stall, 0x1F read arbitration stall.
// - Master codes: read data, write data, five channel stalls.
// - Each event sits at its code offset within its source field.
// - Secure events need secure enables; exempt events pass without them.
// - Writes to a disabled counter have no effect.
// - Global events occupy export bits 15 down to 0.
module perf_event_monitor
    import perf_monitor_pkg::*;
#(
    parameter logic [NUM_SI-1:0] SI_PRESENT = 7'h7F,
    parameter logic [NUM_SI-1:0] SI_ACE     = 7'h0F,
    parameter logic [NUM_MP-1:0] MP_PRESENT = 6'h3F
) (
    input  wire logic                             i_clock,
    input  wire logic                             i_rst,
    input  wire logic                             i_invasive_debug_enable,
    input  wire logic                             i_noninvasive_debug_enable,
    input  wire logic                             i_secure_noninvasive_enable,
    input  wire logic                             i_secure_invasive_enable,
    input  wire logic                             i_global_start,
    input  wire logic                             i_global_cnt_reset,
    input  wire logic [NUM_CNT-1:0]               i_cnt_enable,
    input  wire logic [NUM_CNT-1:0][SEL_W-1:0]    i_evt_sel,
    input  wire logic [NUM_CNT-1:0]               i_cnt_wr,
    input  wire logic [CNT_W-1:0]                 i_cnt_wdata,
    input  wire logic [NUM_CNT-1:0]               i_ovf_clear,
    input  wire logic [NUM_SI-1:0]                i_si_arvalid,
    input  wire logic [NUM_SI-1:0]                i_si_arready,
    input  wire logic [NUM_SI-1:0][2:0]           i_si_ar_kind,
    input  wire logic [NUM_SI-1:0]                i_si_ar_secure,
    input  wire logic [NUM_SI-1:0]                i_si_rvalid,
    input  wire logic [NUM_SI-1:0]                i_si_rready,
    input  wire logic [NUM_SI-1:0]                i_si_rlast,
    input  wire logic [NUM_SI-1:0]                i_si_r_snoop_hit,
    input  wire logic [NUM_SI-1:0]                i_si_awvalid,
    input  wire logic [NUM_SI-1:0]                i_si_awready,
    input  wire logic [NUM_SI-1:0][2:0]           i_si_aw_kind,
    input  wire logic [NUM_SI-1:0]                i_si_aw_secure,
    input  wire logic [NUM_SI-1:0]                i_si_wvalid,
    input  wire logic [NUM_SI-1:0]                i_si_wready,
    input  wire logic [NUM_SI-1:0]                i_si_bvalid,
    input  wire logic [NUM_SI-1:0]                i_si_bready,
    input  wire logic [NUM_SI-1:0]                i_si_acvalid,
    input  wire logic [NUM_SI-1:0]                i_si_acready,
    input  wire logic [NUM_SI-1:0][1:0]           i_si_ac_kind,
    input  wire logic [NUM_SI-1:0]                i_si_ac_secure,
    input  wire logic [NUM_SI-1:0]                i_si_crvalid,
    input  wire logic [NUM_SI-1:0]                i_si_crready,
    input  wire logic [NUM_SI-1:0]                i_si_crresp0,
    input  wire logic [NUM_SI-1:0]                i_si_cdvalid,
    input  wire logic [NUM_SI-1:0]                i_si_cdready,
    input  wire logic [NUM_SI-1:0]                i_si_lim_stall,
    input  wire logic [NUM_SI-1:0]                i_si_arb_stall,
    input  wire logic [NUM_SI-1:0]                i_si_stall_secure,
    input  wire logic [NUM_MP-1:0]                i_mp_arvalid,
    input  wire logic [NUM_MP-1:0]                i_mp_arready,
    input  wire logic [NUM_MP-1:0]                i_mp_ar_secure,
    input  wire logic [NUM_MP-1:0]                i_mp_rvalid,
    input  wire logic [NUM_MP-1:0]                i_mp_rready,
    input  wire logic [NUM_MP-1:0]                i_mp_awvalid,
    input  wire logic [NUM_MP-1:0]                i_mp_awready,
    input  wire logic [NUM_MP-1:0]                i_mp_aw_secure,
    input  wire logic [NUM_MP-1:0]                i_mp_wvalid,
    input  wire logic [NUM_MP-1:0]                i_mp_wready,
    input  wire logic [NUM_MP-1:0]                i_mp_bvalid,
    input  wire logic [NUM_MP-1:0]                i_mp_bready,
    input  wire logic [GLB_EVT_W-1:0]             i_glb_events,
    input  wire logic [GLB_EVT_W-1:0]             i_glb_secure,
    output logic      [BUS_W-1:0]                 o_event_export_bus,
    output logic      [NUM_CNT-1:0][CNT_W-1:0]    o_count,
    output logic      [NUM_CNT-1:0]               o_counter_overflow_n
);
    ////////////////////////////////////////////////////////////////////////
    // Debug enable pins: three-stage capture, accepted once the last two stages agree
    logic [3:0] s1_ff;
    logic [3:0] s2_ff;
    logic [3:0] s3_ff;
    logic [3:0] dbg_ff;
    logic [3:0] nxt_dbg;
    logic       start_ff;
    logic       nxt_start;
    logic       dbg_ok;
    logic       sec_ok;

    always_comb begin
        nxt_dbg   = (s2_ff == s3_ff) ? s3_ff : dbg_ff;
        nxt_start = i_global_start;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s1_ff    <= DBG_RST;
            s2_ff    <= DBG_RST;
            s3_ff    <= DBG_RST;
            dbg_ff   <= DBG_RST;
            start_ff <= START_RST;
        end else begin
            s1_ff    <= {i_secure_invasive_enable, i_secure_noninvasive_enable,
                         i_noninvasive_debug_enable, i_invasive_debug_enable};
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            dbg_ff   <= nxt_dbg;
            start_ff <= nxt_start;
        end
    end

    assign dbg_ok = dbg_ff[0] | dbg_ff[1];
    assign sec_ok = dbg_ff[2] | (dbg_ff[0] & dbg_ff[3]);

    ////////////////////////////////////////////////////////////////////////
    // Raw events, one independent generator per port
    logic [BUS_W-1:0] raw_bus;
    logic [BUS_W-1:0] sec_bus;
    logic [BUS_W-1:0] exempt_bus;

    assign raw_bus[GLB_EVT_W-1:0]    = i_glb_events;
    assign sec_bus[GLB_EVT_W-1:0]    = i_glb_secure;
    assign exempt_bus[GLB_EVT_W-1:0] = GLB_EXEMPT;

    for (genvar p = 0; p < NUM_SI; p++) begin : g_si
        logic [SI_EVT_W-1:0] ev;
        logic                ar_hs;
        logic                aw_hs;
        logic                ac_hs;
        always_comb begin
            ar_hs = i_si_arvalid[p] & i_si_arready[p];
            aw_hs = i_si_awvalid[p] & i_si_awready[p];
            ac_hs = i_si_acvalid[p] & i_si_acready[p];
            ev    = '0;
            // Each bit is a single level, so an event fires once per cycle
            ev[SI_AR_ANY] = ar_hs;
            if (i_si_ar_kind[p] != 3'h0) begin
                ev[32'(i_si_ar_kind[p])] = ar_hs;
            end
            ev[SI_R_HS]  = i_si_rvalid[p] & i_si_rready[p];
            ev[SI_R_HIT] = ev[SI_R_HS] & i_si_rlast[p] & i_si_r_snoop_hit[p];
            ev[SI_AW_ANY] = aw_hs;
            if (i_si_aw_kind[p] != 3'h0 && i_si_aw_kind[p] != 3'h7) begin
                ev[SI_AW_ANY + 32'(i_si_aw_kind[p])] = aw_hs;
            end
            ev[SI_AW_WEVCT] = 1'b0;
            ev[SI_W_HS]     = i_si_wvalid[p] & i_si_wready[p];
            ev[SI_AC_ANY]   = ac_hs;
            ev[SI_AC_READ]  = ac_hs & (i_si_ac_kind[p] == 2'h1);
            ev[SI_AC_CLEAN] = ac_hs & (i_si_ac_kind[p] == 2'h2);
            ev[SI_CR_NODAT] = i_si_crvalid[p] & i_si_crready[p]
                              & ~i_si_crresp0[p];
            ev[SI_STL_AR + 0] = i_si_arvalid[p] & ~i_si_arready[p];
            ev[SI_STL_AR + 1] = i_si_rvalid[p] & ~i_si_rready[p];
            ev[SI_STL_AR + 2] = i_si_awvalid[p] & ~i_si_awready[p];
            ev[SI_STL_AR + 3] = i_si_wvalid[p] & ~i_si_wready[p];
            ev[SI_STL_AR + 4] = i_si_bvalid[p] & ~i_si_bready[p];
            ev[SI_STL_AR + 5] = i_si_acvalid[p] & ~i_si_acready[p];
            ev[SI_STL_AR + 6] = i_si_cdvalid[p] & ~i_si_cdready[p];
            ev[SI_STL_LIM]    = i_si_lim_stall[p];
            ev[SI_STL_ARB]    = i_si_arb_stall[p];
            if (!SI_ACE[p]) begin
                ev = ev & ~SI_ACEONLY;
            end
            if (!SI_PRESENT[p]) begin
                ev = '0;
            end
        end
        // Field position is fixed by port index, present or not
        assign raw_bus[SI_BASE + p*SI_EVT_W +: SI_EVT_W] = ev;
        assign sec_bus[SI_BASE + p*SI_EVT_W +: SI_EVT_W] =
            ({SI_EVT_W{i_si_ar_secure[p]}} & SI_AR_SEC)
            | ({SI_EVT_W{i_si_aw_secure[p]}} & SI_AW_SEC)
            | ({SI_EVT_W{i_si_ac_secure[p]}} & SI_AC_SEC)
            | ({SI_EVT_W{i_si_stall_secure[p]}} & SI_RQ_SEC);
        assign exempt_bus[SI_BASE + p*SI_EVT_W +: SI_EVT_W] = SI_EXEMPT;
    end

    for (genvar m = 0; m < NUM_MP; m++) begin : g_mp
        logic [MP_EVT_W-1:0] ev;
        always_comb begin
            ev            = '0;
            ev[MP_R_HS]   = i_mp_rvalid[m] & i_mp_rready[m];
            ev[MP_W_HS]   = i_mp_wvalid[m] & i_mp_wready[m];
            ev[MP_STL_AR + 0] = i_mp_arvalid[m] & ~i_mp_arready[m];
            ev[MP_STL_AR + 1] = i_mp_rvalid[m] & ~i_mp_rready[m];
            ev[MP_STL_AR + 2] = i_mp_awvalid[m] & ~i_mp_awready[m];
            ev[MP_STL_AR + 3] = i_mp_wvalid[m] & ~i_mp_wready[m];
            ev[MP_STL_AR + 4] = i_mp_bvalid[m] & ~i_mp_bready[m];
            if (!MP_PRESENT[m]) begin
                ev = '0;
            end
        end
        assign raw_bus[MP_BASE + m*MP_EVT_W +: MP_EVT_W] = ev;
        assign sec_bus[MP_BASE + m*MP_EVT_W +: MP_EVT_W] =
            ({MP_EVT_W{i_mp_ar_secure[m]}} & MP_AR_SEC)
            | ({MP_EVT_W{i_mp_aw_secure[m]}} & MP_AW_SEC);
        assign exempt_bus[MP_BASE + m*MP_EVT_W +: MP_EVT_W] = MP_EXEMPT;
    end

    ////////////////////////////////////////////////////////////////////////
    // Security and debug filter, then the registered export bus
    logic [BUS_W-1:0] bus_ff;
    logic [BUS_W-1:0] nxt_bus;

    always_comb begin
        nxt_bus = raw_bus & (~sec_bus | exempt_bus
                  | {BUS_W{sec_ok}});
        if (!dbg_ok) begin
            nxt_bus = '0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            bus_ff <= '0;
        end else begin
            bus_ff <= nxt_bus;
        end
    end

    assign o_event_export_bus = bus_ff;

    ////////////////////////////////////////////////////////////////////////
    // Event selection; counters read the registered bus, one cycle behind
    function automatic logic pick(input logic [BUS_W-1:0] bus,
                                  input logic [SEL_W-1:0] sel);
        logic [SID_W-1:0]  sid;
        logic [CODE_W-1:0] code;
        logic              hit;
        sid  = sel[SEL_W-1:CODE_W];
        code = sel[CODE_W-1:0];
        hit  = 1'b0;
        if (sid < SID_W'(NUM_SI)) begin
            hit = bus[SI_BASE + int'(sid)*SI_EVT_W + int'(code)];
        end else if (sid >= SID_MP_FIRST && sid < SID_MP_FIRST + SID_W'(NUM_MP)
                     && code < CODE_W'(MP_EVT_W)) begin
            hit = bus[MP_BASE + int'(sid - SID_MP_FIRST)*MP_EVT_W + int'(code)];
        end else if (sid == SID_GLOBAL && code < CODE_W'(GLB_EVT_W)) begin
            hit = bus[int'(code)];
        end
        // Reserved ids 7 and 14 fall through and never count
        return hit;
    endfunction

    for (genvar c = 0; c < NUM_CNT; c++) begin : g_cnt
        logic sel_event;
        always_comb begin
            sel_event = pick(bus_ff, i_evt_sel[c]);
        end
        perf_counter perf_counter_inst (
            .i_clock      (i_clock),
            .i_rst        (i_rst),
            .i_enable     (i_cnt_enable[c]),
            .i_start      (start_ff),
            .i_event      (sel_event),
            .i_clear      (i_global_cnt_reset),
            .i_wr         (i_cnt_wr[c]),
            .i_wdata      (i_cnt_wdata),
            .i_ovf_clr    (i_ovf_clear[c]),
            .o_count      (o_count[c]),
            .o_overflow_n (o_counter_overflow_n[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);

    a_export_gated: assert property (!dbg_ok |=> bus_ff == '0)
        else $error("events exported with debug disabled");
    a_global_lsb: assert property (dbg_ok |=> bus_ff[GLB_EVT_W-1:0]
        == ($past(i_glb_events) & ($past(~i_glb_secure) | GLB_EXEMPT
        | {GLB_EVT_W{$past(sec_ok)}})))
        else $error("global events misplaced on export bus");
    a_no_wevict: assert property (bus_ff[SI_BASE + SI_AW_WEVCT] == 1'b0)
        else $error("write-evict event fired");
    a_ace_only: assert property (SI_ACE[4] || SI_PRESENT[4] == 1'b0
        || (bus_ff[SI_BASE + 4*SI_EVT_W +: SI_EVT_W] & SI_ACEONLY) == '0)
        else $error("coherent-only event on plain port");
    a_sec_block: assert property (dbg_ok && !sec_ok && i_si_ar_secure[3]
        && i_si_arvalid[3] && i_si_arready[3]
        |=> !bus_ff[SI_BASE + 3*SI_EVT_W + SI_AR_ANY])
        else $error("secure read counted without secure enable");
    a_read_hs: assert property (dbg_ok && i_si_rvalid[0] && i_si_rready[0]
        && SI_PRESENT[0] |=> bus_ff[SI_BASE + SI_R_HS])
        else $error("read data handshake not exported");
endmodule

// >>> logic/perf_monitor_pkg.sv
package perf_monitor_pkg;
    localparam int NUM_CNT   = 8;
    localparam int CNT_W     = 32;
    localparam int SEL_W     = 9;
    localparam int SID_W     = 4;
    localparam int CODE_W    = 5;
    localparam int NUM_SI    = 7;
    localparam int NUM_MP    = 6;
    localparam int GLB_EVT_W = 16;
    localparam int SI_EVT_W  = 32;
    localparam int MP_EVT_W  = 7;
    // Export bus layout: global, then slave fields, then master fields
    localparam int SI_BASE   = GLB_EVT_W;
    localparam int MP_BASE   = SI_BASE + NUM_SI * SI_EVT_W;
    localparam int BUS_W     = MP_BASE + NUM_MP * MP_EVT_W;
    // Source identifiers
    localparam logic [3:0] SID_MP_FIRST = 4'h8;
    localparam logic [3:0] SID_GLOBAL   = 4'hF;
    // Slave event codes used by name
    localparam int SI_AR_ANY   = 32'h00;
    localparam int SI_R_HS     = 32'h08;
    localparam int SI_R_HIT    = 32'h09;
    localparam int SI_AW_ANY   = 32'h0A;
    localparam int SI_AW_WEVCT = 32'h11;
    localparam int SI_W_HS     = 32'h12;
    localparam int SI_AC_ANY   = 32'h13;
    localparam int SI_AC_READ  = 32'h14;
    localparam int SI_AC_CLEAN = 32'h15;
    localparam int SI_CR_NODAT = 32'h16;
    localparam int SI_STL_AR   = 32'h17;
    localparam int SI_STL_LIM  = 32'h1E;
    localparam int SI_STL_ARB  = 32'h1F;
    // Master event codes
    localparam int MP_R_HS     = 32'h00;
    localparam int MP_W_HS     = 32'h01;
    localparam int MP_STL_AR   = 32'h02;
    // Per-field attribute masks, bit n belongs to code n
    localparam logic [31:0] SI_EXEMPT  = 32'h2D440300;
    localparam logic [31:0] SI_ACEONLY = 32'h20332030;
    localparam logic [31:0] SI_AR_SEC  = 32'h008000FF;
    localparam logic [31:0] SI_AW_SEC  = 32'h0203FC00;
    localparam logic [31:0] SI_AC_SEC  = 32'h10380000;
    localparam logic [31:0] SI_RQ_SEC  = 32'hC0000000;
    localparam logic [6:0]  MP_EXEMPT  = 7'h6B;
    localparam logic [6:0]  MP_AR_SEC  = 7'h04;
    localparam logic [6:0]  MP_AW_SEC  = 7'h10;
    localparam logic [15:0] GLB_EXEMPT = 16'hD200;
    // Reset values
    localparam logic [31:0] COUNT_RST  = 32'h00000000;
    localparam logic        START_RST  = 1'b0;
    localparam logic [3:0]  DBG_RST    = 4'h0;
endpackage

// >>> tb/perf_event_monitor_bench.sv
`timescale 1ns/10ps
module perf_event_monitor_bench;
    import perf_monitor_pkg::*;
    logic i_clock, i_rst, i_invasive_debug_enable, i_noninvasive_debug_enable, sec;
    logic i_secure_noninvasive_enable, i_secure_invasive_enable, i_global_start;
    logic i_global_cnt_reset;
    logic [NUM_CNT-1:0] i_cnt_enable, i_cnt_wr, i_ovf_clear, o_counter_overflow_n;
    logic [NUM_CNT-1:0][SEL_W-1:0] i_evt_sel;
    logic [CNT_W-1:0] i_cnt_wdata;
    logic [31:0] seed = 32'h88286E78;
    logic [NUM_SI-1:0] i_si_arvalid, i_si_arready, i_si_ar_secure, i_si_rvalid, i_si_rready,
        i_si_rlast, i_si_r_snoop_hit, i_si_awvalid, i_si_awready, i_si_aw_secure, i_si_wvalid,
        i_si_wready, i_si_bvalid, i_si_bready, i_si_acvalid, i_si_acready, i_si_ac_secure,
        i_si_crvalid, i_si_crready, i_si_crresp0, i_si_cdvalid, i_si_cdready, i_si_lim_stall,
        i_si_arb_stall, i_si_stall_secure, p_wv, p_wr;
    logic [NUM_SI-1:0][2:0] i_si_ar_kind, i_si_aw_kind;
    logic [NUM_SI-1:0][1:0] i_si_ac_kind;
    logic [NUM_MP-1:0] i_mp_arvalid, i_mp_arready, i_mp_ar_secure, i_mp_rvalid, i_mp_rready,
        i_mp_awvalid, i_mp_awready, i_mp_aw_secure, i_mp_wvalid, i_mp_wready, i_mp_bvalid,
        i_mp_bready, p_rv, p_rr, p_av, p_ar, p_as;
    logic [GLB_EVT_W-1:0] i_glb_events, i_glb_secure, p_ge, p_gs;
    logic [BUS_W-1:0] o_event_export_bus;
    logic [NUM_CNT-1:0][CNT_W-1:0] o_count;
    logic [1:0] mode, chk;
    logic [2:0] port, kind;
    logic [319:0] rnd;
    logic [292:0] rv = '0;
    int errors, samples_checked;
    ////////////////////////////////////////////////////////////////////////////////
    perf_event_monitor perf_event_monitor_inst (.*);
    port_model port_model_inst (.i_clock, .i_mode(mode), .i_port(port), .i_kind(kind),
        .i_secure(sec), .o_arvalid(i_si_arvalid), .o_arready(i_si_arready),
        .o_ar_kind(i_si_ar_kind), .o_ar_secure(i_si_ar_secure));
    // All side traffic is random so unselected events keep toggling around the counters
    assign {i_si_rvalid, i_si_rready, i_si_rlast, i_si_r_snoop_hit, i_si_awvalid, i_si_awready,
        i_si_aw_secure, i_si_wvalid, i_si_wready, i_si_bvalid, i_si_bready, i_si_acvalid,
        i_si_acready, i_si_ac_secure, i_si_crvalid, i_si_crready, i_si_crresp0, i_si_cdvalid,
        i_si_cdready, i_si_lim_stall, i_si_arb_stall, i_si_stall_secure, i_si_aw_kind,
        i_si_ac_kind, i_mp_arvalid, i_mp_arready, i_mp_ar_secure, i_mp_rvalid, i_mp_rready,
        i_mp_awvalid, i_mp_awready, i_mp_aw_secure, i_mp_wvalid, i_mp_wready, i_mp_bvalid,
        i_mp_bready, i_glb_events, i_glb_secure} = rv;
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic hs(input logic [2:0] p, input logic [2:0] k, input logic s);
        mode <= 2'h1;
        port <= p;
        kind <= k;
        sec <= s;
        @(posedge i_clock);
        mode <= 2'h0;
        repeat (4) @(posedge i_clock);
    endtask
    task automatic probe(input int i, input logic [31:0] c, input logic [7:0] o);
        @(negedge i_clock);
        check("count", o_count[i], c);
        check("overflow_n", o_counter_overflow_n, o);
        @(posedge i_clock);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clock) begin
        for (int k = 0; k < 10; k++) begin
            seed = lfsr(seed);
            rnd = {rnd[287:0], seed};
        end
        rv <= rnd[292:0];
        {p_wv, p_wr, p_rv, p_rr, p_av, p_ar, p_as, p_ge, p_gs} <= {i_si_wvalid, i_si_wready,
            i_mp_rvalid, i_mp_rready, i_mp_arvalid, i_mp_arready, i_mp_ar_secure,
            i_glb_events, i_glb_secure};
    end
    always @(negedge i_clock) begin
        if (chk == 2'h1) check("bus_off", |o_event_export_bus, 1'b0);
        if (chk == 2'h2) begin
            check("glb", o_event_export_bus[15:0], p_ge & (~p_gs | GLB_EXEMPT));
            for (int m = 0; m < NUM_MP; m++) begin
                check("mp_r", o_event_export_bus[MP_BASE+7*m+MP_R_HS],
                    p_rv[m] & p_rr[m]);
                check("mp_ar_stl", o_event_export_bus[MP_BASE+7*m+MP_STL_AR],
                    p_av[m] & ~p_ar[m] & ~p_as[m]);
            end
            for (int s = 0; s < NUM_SI; s++) begin
                check("si_wev", o_event_export_bus[SI_BASE+32*s+SI_AW_WEVCT], 1'b0);
                check("si_w", o_event_export_bus[SI_BASE+32*s+SI_W_HS],
                    p_wv[s] & p_wr[s]);
                check("si_w_stl", o_event_export_bus[SI_BASE+32*s+SI_STL_AR+3],
                    p_wv[s] & ~p_wr[s]);
            end
        end
    end
    initial begin
        errors = 0;
        samples_checked = 0;
        {i_rst, i_global_start, i_global_cnt_reset, i_invasive_debug_enable} = 4'h8;
        {i_noninvasive_debug_enable, i_secure_noninvasive_enable, i_secure_invasive_enable} = 3'h0;
        {i_cnt_enable, i_cnt_wr, i_ovf_clear, i_cnt_wdata, i_evt_sel} = '0;
        {mode, port, kind, sec, chk} = '0;
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        i_cnt_enable <= 8'h03;
        i_evt_sel[0] <= 9'h063;
        i_evt_sel[1] <= 9'h0A4;
        i_global_start <= 1'b1;
        chk <= 2'h1;
        probe(0, 32'h0, 8'hFF);
        hs(3'h3, 3'h3, 1'b0);
        probe(0, 32'h0, 8'hFF);
        chk <= 2'h0;
        i_noninvasive_debug_enable <= 1'b1;
        repeat (8) @(posedge i_clock);
        chk <= 2'h2;
        hs(3'h3, 3'h3, 1'b0);
        probe(0, 32'h1, 8'hFF);
        hs(3'h5, 3'h4, 1'b0);
        probe(1, 32'h0, 8'hFF);
        i_evt_sel[1] <= 9'h0A0;
        hs(3'h5, 3'h4, 1'b0);
        probe(1, 32'h1, 8'hFF);
        hs(3'h3, 3'h3, 1'b1);
        probe(0, 32'h1, 8'hFF);
        i_global_start <= 1'b0;
        hs(3'h3, 3'h3, 1'b0);
        probe(0, 32'h1, 8'hFF);
        {i_global_start, i_cnt_enable, i_cnt_wr, i_cnt_wdata} <= {1'b1, 16'h0102, 32'h5};
        @(posedge i_clock);
        i_cnt_wr <= 8'h01;
        i_cnt_wdata <= 32'hFFFFFFFF;
        @(posedge i_clock);
        i_cnt_wr <= 8'h00;
        probe(1, 32'h1, 8'hFF);
        probe(0, 32'hFFFFFFFF, 8'hFF);
        hs(3'h3, 3'h3, 1'b0);
        probe(0, 32'h0, 8'hFE);
        i_ovf_clear <= 8'h01;
        hs(3'h3, 3'h3, 1'b0);
        i_ovf_clear <= 8'h00;
        probe(0, 32'h1, 8'hFF);
        i_global_cnt_reset <= 1'b1;
        @(posedge i_clock);
        i_global_cnt_reset <= 1'b0;
        probe(0, 32'h0, 8'hFF);
        repeat (200) @(posedge i_clock);
        finish_test();
    end
endmodule

// >>> tb/port_model.sv
`timescale 1ns/10ps
module port_model
    import perf_monitor_pkg::*;
(
    input  wire logic                   i_clock,
    input  wire logic [1:0]             i_mode,
    input  wire logic [2:0]             i_port,
    input  wire logic [2:0]             i_kind,
    input  wire logic                   i_secure,
    output logic      [NUM_SI-1:0]      o_arvalid,
    output logic      [NUM_SI-1:0]      o_arready,
    output logic      [NUM_SI-1:0][2:0] o_ar_kind,
    output logic      [NUM_SI-1:0]      o_ar_secure
);
    // Mode 1 handshakes, mode 2 stalls; idle ports carry the inverse kind
    always_ff @(posedge i_clock) begin
        o_arvalid <= (i_mode != 2'h0) ? (7'h01 << i_port) : 7'h00;
        o_arready <= (i_mode == 2'h1) ? (7'h01 << i_port) : 7'h00;
        o_ar_kind <= {NUM_SI{~i_kind}};
        o_ar_kind[i_port] <= i_kind;
        o_ar_secure <= {NUM_SI{i_secure}};
    end
endmodule
